/* rtl/smbsl_pkg.sv */
package smbsl_pkg;
   // reference clock
   localparam int unsigned REF_CLK_HZ          = 250_000_000;
   // clock-low timeout window in ms; the device acts at the lower bound plus margin
   localparam int unsigned TIMEOUT_MIN_MS      = 25;
   localparam int unsigned TIMEOUT_MAX_MS      = 35;
   localparam int unsigned TIMEOUT_USE_MS      = 30;
   localparam longint unsigned TIMEOUT_CYCLES  =
      (longint'(REF_CLK_HZ) / 1000) * TIMEOUT_USE_MS;
   // power-on to ready, a longest time, rounds down
   localparam int unsigned READY_MAX_MS        = 500;
   localparam longint unsigned READY_CYCLES    =
      (longint'(REF_CLK_HZ) / 1000) * READY_MAX_MS;
   // frame shape
   localparam int unsigned DATA_BITS           = 8;
   localparam int unsigned ADDR_BITS           = 7;
   localparam logic [6:0]  DEFAULT_ADDR        = 7'h2E;
   // glitch filter length in reference cycles
   localparam int unsigned FILT_LEN            = 4;
   // master phase length in reference cycles, a quarter of the clock period (32 ns -> 8 cycles at 4 ns)
   localparam int unsigned HALF_PERIOD_CYC     = 8;
   localparam logic [3:0]  BIT_LAST            = 4'h7;
   localparam logic [3:0]  BIT_ACK             = 4'h8;

   typedef enum logic [2:0]
   {
      SMBSL_IDLE = 3'b000,
      SMBSL_ADDR = 3'b001,
      SMBSL_RXB  = 3'b010,
      SMBSL_TXB  = 3'b011,
      SMBSL_ACK  = 3'b100,
      SMBSL_MACK = 3'b101,
      SMBSL_IGN  = 3'b110
   } smbsl_state_type;

   typedef enum logic [2:0]
   {
      SMBSM_IDLE  = 3'b000,
      SMBSM_START = 3'b001,
      SMBSM_BIT   = 3'b010,
      SMBSM_ACK   = 3'b011,
      SMBSM_STOP  = 3'b100,
      SMBSM_DONE  = 3'b101
   } smbsm_state_type;
endpackage

/* rtl/smbsl_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface smbsl_link_if;
   // master side
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   // slave side (clock never driven by the slave)
   logic s_sda_o;
   logic s_sda_oe;
   // resolved wired-and levels, pulled up when nobody drives low
   logic serial_clock_pin;
   logic serial_data_pin;
   assign serial_clock_pin = !(m_scl_oe && !m_scl_o);
   assign serial_data_pin  = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
   modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                   input serial_clock_pin, input serial_data_pin);
   modport slave  (output s_sda_o, output s_sda_oe,
                   input serial_clock_pin, input serial_data_pin);
endinterface
`default_nettype wire

/* rtl/smbsl_slave.sv */
// Operation
// [RULE1] clock low past timeout resets, releases data
// [RULE2] master alone makes clock and transfers
// [RULE3] one data bit per clock cycle
// [RULE4] nine-clock frames, eight bits msb first
// [RULE5] no idle clocks inside a transfer
// [RULE6] data changes only while clock low
// [RULE7] device never makes start or stop
// [RULE8] data fall with clock high is start
// [RULE9] data rise with clock high is stop
// [RULE10] device acks each received byte, whole ninth clock
// [RULE11] master nacks last read byte then stops
// [RULE12] reads always return latest completed result
// [RULE13] operational within 500 ms of reset
// [RULE14] acknowledge only own seven-bit address
// [RULE15] synchronise and filter clock and data first
`timescale 1ns/10ps
`default_nettype none
module smbsl_slave
   import smbsl_pkg::*;
#(
   parameter logic [6:0]      OWN_ADDR    = DEFAULT_ADDR,
   parameter longint unsigned TIMEOUT_CYC = TIMEOUT_CYCLES,
   parameter longint unsigned READY_CYC   = READY_CYCLES
)
(
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   // link
   smbsl_link_if.slave     link,
   // user side: byte to send on reads, latest completed result
   input  wire logic [7:0] i_tx_data,
   // user side: received bytes and bus status
   output logic [7:0]      o_rx_data,
   output logic            o_rx_valid,
   output logic            o_rx_first,
   output logic            o_tx_taken,
   output logic            o_start,
   output logic            o_stop,
   output logic            o_timeout,
   output logic            o_ready
);
   ////////////////////////////////////////////////////////////////////////////////
   // synchronise and filter both lines
   logic [1:0] scl_sync_q, sda_sync_q;
   logic [2:0] scl_cnt_q, scl_cnt_d, sda_cnt_q, sda_cnt_d;
   logic       scl_q, scl_d, sda_q, sda_d;

   function automatic logic [2:0] filt_step(input logic raw, input logic cur,
                                            input logic [2:0] cnt);
      if (raw == cur)
         filt_step = 3'h0;
      else
         filt_step = cnt + 3'h1;
   endfunction

   always_comb
   begin
      scl_cnt_d = filt_step(scl_sync_q[1], scl_q, scl_cnt_q); // [RULE15]
      sda_cnt_d = filt_step(sda_sync_q[1], sda_q, sda_cnt_q); // [RULE15]
      scl_d     = scl_q;
      sda_d     = sda_q;
      if (scl_cnt_d == 3'(FILT_LEN))
      begin
         scl_d     = scl_sync_q[1];
         scl_cnt_d = 3'h0;
      end
      if (sda_cnt_d == 3'(FILT_LEN))
      begin
         sda_d     = sda_sync_q[1];
         sda_cnt_d = 3'h0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_cnt_q  <= 3'h0;
         sda_cnt_q  <= 3'h0;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], link.serial_clock_pin};
         sda_sync_q <= {sda_sync_q[0], link.serial_data_pin};
         scl_cnt_q  <= scl_cnt_d;
         sda_cnt_q  <= sda_cnt_d;
         scl_q      <= scl_d;
         sda_q      <= sda_d;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise  = scl_d && !scl_q;
   assign scl_fall  = !scl_d && scl_q;
   // filtered edges: data moving with clock held high
   assign start_det = scl_q && scl_d && sda_q && !sda_d; // [RULE8]
   assign stop_det  = scl_q && scl_d && !sda_q && sda_d; // [RULE9]

   ////////////////////////////////////////////////////////////////////////////////
   // timeout and power-up ready counters
   logic [31:0] low_cnt_q, low_cnt_d, rdy_cnt_q, rdy_cnt_d;
   logic        tmo;

   always_comb
   begin
      low_cnt_d = scl_q ? 32'h0 : low_cnt_q + 32'h1;
      tmo       = (low_cnt_q == 32'(TIMEOUT_CYC)); // [RULE1]
      rdy_cnt_d = rdy_cnt_q;
      if (tmo)
         low_cnt_d = low_cnt_q;
      if (rdy_cnt_q != 32'(READY_CYC))
         rdy_cnt_d = rdy_cnt_q + 32'h1;
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         low_cnt_q <= 32'h0;
         rdy_cnt_q <= 32'h0;
      end
      else
      begin
         low_cnt_q <= low_cnt_d;
         rdy_cnt_q <= rdy_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus state machine
   smbsl_state_type st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, rx_q, rx_d;
   logic       sda_low_q, sda_low_d, rxv_q, rxv_d, first_q, first_d, tk_q, tk_d;

   always_comb
   begin
      st_d      = st_q;
      bit_d     = bit_q;
      sh_d      = sh_q;
      rx_d      = rx_q;
      sda_low_d = sda_low_q;
      rxv_d     = 1'b0;
      first_d   = first_q;
      tk_d      = 1'b0;
      if (tmo || stop_det)
      begin
         // stop or stuck clock: back to idle, data line released
         st_d      = SMBSL_IDLE; // [RULE1] [RULE9]
         sda_low_d = 1'b0;
      end
      else if (start_det)
      begin
         st_d      = SMBSL_ADDR; // [RULE8] repeated start too
         bit_d     = 4'h0;
         sda_low_d = 1'b0;
      end
      else if (scl_rise && (st_q == SMBSL_ADDR || st_q == SMBSL_RXB))
      begin
         sh_d  = {sh_q[6:0], sda_q}; // [RULE3] [RULE4] msb first
         bit_d = bit_q + 4'h1;
      end
      else if (scl_rise && st_q == SMBSL_MACK && sda_q)
         st_d = SMBSL_IGN; // [RULE11] nack ends read, wait for stop
      else if (scl_fall)
      begin
         // every data change happens right after the clock falls, except the release on timeout
         case (st_q)
            SMBSL_ADDR, SMBSL_RXB:
               if (bit_q == 4'(DATA_BITS))
               begin
                  if (st_q == SMBSL_ADDR && sh_q[7:1] != OWN_ADDR)
                     st_d = SMBSL_IGN; // [RULE14]
                  else
                  begin
                     st_d      = SMBSL_ACK;
                     sda_low_d = 1'b1; // [RULE10] [RULE6]
                     if (st_q == SMBSL_RXB)
                     begin
                        rx_d  = sh_q;
                        rxv_d = 1'b1;
                     end
                     else
                        first_d = 1'b1;
                  end
               end
            SMBSL_ACK:
            begin
               bit_d = 4'h0;
               if (first_q && sh_q[0])
               begin
                  // read: send the latest result from the user side
                  st_d      = SMBSL_TXB; // [RULE12]
                  sh_d      = {i_tx_data[6:0], 1'b0};
                  sda_low_d = !i_tx_data[7];
                  tk_d      = 1'b1;
               end
               else
               begin
                  st_d      = SMBSL_RXB; // [RULE5]
                  sda_low_d = 1'b0;
               end
               if (st_q == SMBSL_ACK && !(first_q && sh_q[0]))
                  first_d = first_q;
            end
            SMBSL_TXB:
            begin
               bit_d = bit_q + 4'h1;
               if (bit_q == BIT_LAST)
               begin
                  st_d      = SMBSL_MACK;
                  sda_low_d = 1'b0;
               end
               else
               begin
                  sda_low_d = !sh_q[7]; // [RULE6]
                  sh_d      = {sh_q[6:0], 1'b0};
               end
            end
            SMBSL_MACK:
            begin
               // master acked: next byte follows at once
               st_d      = SMBSL_TXB; // [RULE5]
               bit_d     = 4'h0;
               sh_d      = {i_tx_data[6:0], 1'b0};
               sda_low_d = !i_tx_data[7];
               tk_d      = 1'b1;
            end
            default:
               st_d = st_q;
         endcase
      end
      if (st_q == SMBSL_ACK && scl_fall && first_q && !sh_q[0])
         first_d = 1'b1;
      // keep the flag through the valid pulse so o_rx_first can show it
      if (rxv_q)
         first_d = 1'b0;
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_q      <= SMBSL_IDLE;
         bit_q     <= 4'h0;
         sh_q      <= 8'h00;
         rx_q      <= 8'h00;
         sda_low_q <= 1'b0;
         rxv_q     <= 1'b0;
         first_q   <= 1'b0;
         tk_q      <= 1'b0;
      end
      else
      begin
         st_q      <= st_d;
         bit_q     <= bit_d;
         sh_q      <= sh_d;
         rx_q      <= rx_d;
         sda_low_q <= sda_low_d;
         rxv_q     <= rxv_d;
         first_q   <= first_d;
         tk_q      <= tk_d;
      end
   end

   // open drain: only ever pulls low, never touches the clock
   assign link.s_sda_o  = 1'b0; // [RULE2] [RULE7]
   assign link.s_sda_oe = sda_low_q;
   assign o_rx_data     = rx_q;
   assign o_rx_valid    = rxv_q;
   assign o_rx_first    = rxv_q && first_q;
   assign o_tx_taken    = tk_q;
   assign o_start       = start_det;
   assign o_stop        = stop_det;
   assign o_timeout     = tmo;
   assign o_ready       = (rdy_cnt_q == 32'(READY_CYC)); // [RULE13]
endmodule
`default_nettype wire

/* rtl/smbsl_master.sv */
`timescale 1ns/10ps
`default_nettype none
module smbsl_master
   import smbsl_pkg::*;
#(
   parameter int unsigned HALF_CYC = HALF_PERIOD_CYC
)
(
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   // link
   smbsl_link_if.master    link,
   // user side: one byte transfer request and its status
   input  wire logic       i_req,
   input  wire logic [7:0] i_byte,
   input  wire logic       i_read,
   input  wire logic       i_start,
   input  wire logic       i_stop,
   input  wire logic       i_last,
   output logic            o_busy,
   output logic            o_done,
   output logic [7:0]      o_rx_byte,
   output logic            o_acked
);
   // master drives the clock from a divider; one phase per enable
   logic [7:0] div_q, div_d;
   logic       tick;
   smbsm_state_type st_q, st_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic       scl_q, scl_d, sda_q, sda_d, rd_q, rd_d, stp_q, stp_d, lst_q, lst_d;
   logic       ack_q, ack_d, done_q, done_d;
   logic [1:0] din_sync_q;

   assign tick = (div_q == 8'(HALF_CYC - 1));

   always_comb
   begin
      div_d  = tick ? 8'h00 : div_q + 8'h01;
      st_d   = st_q;
      ph_d   = ph_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      scl_d  = scl_q;
      sda_d  = sda_q;
      rd_d   = rd_q;
      stp_d  = stp_q;
      lst_d  = lst_q;
      ack_d  = ack_q;
      done_d = 1'b0;
      if (st_q == SMBSM_IDLE || st_q == SMBSM_DONE)
      begin
         if (st_q == SMBSM_DONE)
            st_d = SMBSM_IDLE;
         else if (i_req)
         begin
            sh_d  = i_byte;
            rd_d  = i_read;
            stp_d = i_stop;
            lst_d = i_last;
            bit_d = 4'h0;
            ph_d  = 2'h0;
            st_d  = i_start ? SMBSM_START : SMBSM_BIT;
         end
      end
      else if (tick)
      begin
         ph_d = ph_q + 2'h1;
         case (st_q)
            SMBSM_START:
               // 0: release data, 1: clock high, 2: data low, 3: clock low
               case (ph_q)
                  2'h0: sda_d = 1'b1;
                  2'h1: scl_d = 1'b1;
                  2'h2: sda_d = 1'b0;
                  default:
                  begin
                     scl_d = 1'b0;
                     ph_d  = 2'h0;
                     st_d  = SMBSM_BIT;
                  end
               endcase
            SMBSM_BIT, SMBSM_ACK:
               // data set while clock low, sampled one phase after the rising edge
               case (ph_q)
                  2'h0:
                     if (st_q == SMBSM_BIT)
                        sda_d = rd_q ? 1'b1 : sh_q[7];
                     else
                        sda_d = rd_q ? lst_q : 1'b1; // [RULE11]
                  2'h1: scl_d = 1'b1;
                  2'h2:
                     if (st_q == SMBSM_BIT)
                        sh_d = {sh_q[6:0], din_sync_q[1]};
                     else if (!rd_q)
                        ack_d = !din_sync_q[1];
                     else
                        ack_d = 1'b1;
                  default:
                  begin
                     scl_d = 1'b0;
                     ph_d  = 2'h0;
                     if (st_q == SMBSM_BIT)
                     begin
                        bit_d = bit_q + 4'h1;
                        if (bit_q == BIT_LAST)
                           st_d = SMBSM_ACK;
                     end
                     else
                        st_d = stp_q ? SMBSM_STOP : SMBSM_DONE;
                     if (st_q == SMBSM_ACK && !stp_q)
                        done_d = 1'b1;
                  end
               endcase
            SMBSM_STOP:
               case (ph_q)
                  2'h0: sda_d = 1'b0;
                  2'h1: scl_d = 1'b1;
                  2'h2: sda_d = 1'b1;
                  default:
                  begin
                     st_d   = SMBSM_DONE;
                     done_d = 1'b1;
                  end
               endcase
            default:
               st_d = SMBSM_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         div_q      <= 8'h00;
         st_q       <= SMBSM_IDLE;
         ph_q       <= 2'h0;
         bit_q      <= 4'h0;
         sh_q       <= 8'h00;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         rd_q       <= 1'b0;
         stp_q      <= 1'b0;
         lst_q      <= 1'b0;
         ack_q      <= 1'b0;
         done_q     <= 1'b0;
         din_sync_q <= 2'h3;
      end
      else
      begin
         div_q      <= div_d;
         st_q       <= st_d;
         ph_q       <= ph_d;
         bit_q      <= bit_d;
         sh_q       <= sh_d;
         scl_q      <= scl_d;
         sda_q      <= sda_d;
         rd_q       <= rd_d;
         stp_q      <= stp_d;
         lst_q      <= lst_d;
         ack_q      <= ack_d;
         done_q     <= done_d;
         din_sync_q <= {din_sync_q[0], link.serial_data_pin};
      end
   end

   // open drain on both lines
   assign link.m_scl_o  = 1'b0;
   assign link.m_scl_oe = !scl_q; // [RULE2]
   assign link.m_sda_o  = 1'b0;
   assign link.m_sda_oe = !sda_q;
   assign o_busy        = (st_q != SMBSM_IDLE);
   assign o_done        = done_q;
   assign o_rx_byte     = sh_q;
   assign o_acked       = ack_q;
endmodule
`default_nettype wire

/* test/smbsl_link_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module smbsl_link_asserts
   import smbsl_pkg::*;
#(
   parameter logic [6:0] OWN_ADDR = DEFAULT_ADDR
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // link
   input wire logic s_sda_oe,
   input wire logic serial_clock_pin,
   input wire logic serial_data_pin
);
   logic       scl_q, sda_q, act_q, act_d, first_q, first_d;
   logic       rw_q, rw_d, match_q, match_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sr_q, sr_d;
   logic       rise, start, stop, at9;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   ////////////////////////////////////////////////////////////////////////////////
   // frame tracker, pins are already clean register outputs so no filter here
   assign rise  = serial_clock_pin && !scl_q;
   assign start = serial_clock_pin && scl_q && sda_q && !serial_data_pin;
   assign stop  = serial_clock_pin && scl_q && !sda_q && serial_data_pin;
   assign at9   = rise && act_q && (bit_q == 4'h8);

   always_comb
   begin
      act_d   = act_q;
      bit_d   = bit_q;
      first_d = first_q;
      rw_d    = rw_q;
      match_d = match_q;
      sr_d    = sr_q;
      if (rise && act_q)
      begin
         bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
         if (bit_q < 4'h8)
            sr_d = {sr_q[6:0], serial_data_pin};
         if (at9)
            first_d = 1'b0;
         if (at9 && first_q)
         begin
            rw_d    = sr_q[0];
            match_d = (sr_q[7:1] == OWN_ADDR);
         end
      end
      if (start)
      begin
         act_d   = 1'b1;
         bit_d   = 4'h0;
         first_d = 1'b1;
         match_d = 1'b0;
      end
      if (stop)
         act_d = 1'b0;
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         {scl_q, sda_q, act_q, first_q, rw_q, match_q} <= 6'h30;
         bit_q <= 4'h0;
         sr_q  <= 8'h00;
      end
      else
      begin
         {scl_q, sda_q, act_q, first_q, rw_q, match_q} <=
            {serial_clock_pin, serial_data_pin, act_d, first_d, rw_d, match_d};
         bit_q <= bit_d;
         sr_q  <= sr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_hold_high;
      serial_clock_pin && scl_q |-> $stable(s_sda_oe);
   endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("slave data moved in clock high");
   property p_change_low;
      $changed(s_sda_oe) |-> !serial_clock_pin && !scl_q;
   endproperty
   a_change_low: assert property (p_change_low)
      else $error("slave made a bus condition");
   property p_addr_ack;
      at9 && first_q && (sr_q[7:1] == OWN_ADDR) |-> s_sda_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("own address not acked");
   property p_addr_ignore;
      at9 && first_q && (sr_q[7:1] != OWN_ADDR) |-> !s_sda_oe [*8];
   endproperty
   a_addr_ignore: assert property (p_addr_ignore)
      else $error("foreign address acked");
   property p_write_ack;
      at9 && !first_q && match_q && !rw_q |-> s_sda_oe;
   endproperty
   a_write_ack: assert property (p_write_ack)
      else $error("written byte not acked");
   property p_read_release;
      at9 && !first_q && rw_q |-> !s_sda_oe;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("slave held master ack");
   property p_ack_holds;
      at9 && s_sda_oe |-> s_sda_oe [*8];
   endproperty
   a_ack_holds: assert property (p_ack_holds)
      else $error("ack dropped in ninth clock");
   property p_sync_delay;
      $fell(serial_clock_pin) |-> $stable(s_sda_oe) [*5];
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("slave reacted unfiltered");
   property p_stop_idle;
      stop |-> !s_sda_oe [*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("slave drove after stop");

   c_write_ack: cover property (at9 && !first_q && !rw_q && s_sda_oe);
   c_read_byte: cover property (at9 && !first_q && rw_q);
   c_foreign:   cover property (at9 && first_q && !s_sda_oe);
   c_stop:      cover property (stop);
endmodule
`default_nettype wire

/* test/smbus_slave_bus_interface_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin samples_checked++; if ((got) !== (ex)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module smbus_slave_bus_interface_tb
   import smbsl_pkg::*;
();
   localparam int TO_CYC  = 2000;
   localparam int RDY_CYC = 100;
   logic       clk, rst, req, rd, st, sp, last, busy, done, acked;
   logic       srv, sfirst, staken, sstart, sstop, srdy, sstart2, sto2, lastfirst;
   logic [7:0] byt, txd, rxb, srx, lastrx, a;
   logic [8:0] wire_sr;
   int         errors, samples_checked, nrx, nstart, nstop, ntaken, nstart2, i;

   smbsl_link_if smbsl_link_if_i();
   smbsl_link_if smbsl_link_if_2();
   smbsl_master smbsl_master_i (.i_ref_clk(clk), .i_reset(rst), .link(smbsl_link_if_i),
      .i_req(req), .i_byte(byt), .i_read(rd), .i_start(st), .i_stop(sp), .i_last(last),
      .o_busy(busy), .o_done(done), .o_rx_byte(rxb), .o_acked(acked));
   smbsl_slave #(.TIMEOUT_CYC(TO_CYC), .READY_CYC(RDY_CYC)) smbsl_slave_i (.i_ref_clk(clk),
      .i_reset(rst), .link(smbsl_link_if_i), .i_tx_data(txd), .o_rx_data(srx),
      .o_rx_valid(srv), .o_rx_first(sfirst), .o_tx_taken(staken), .o_start(sstart),
      .o_stop(sstop), .o_timeout(), .o_ready(srdy));
   // second slave faces the bench, which breaks the clock rules on purpose
   smbsl_slave #(.TIMEOUT_CYC(TO_CYC), .READY_CYC(RDY_CYC)) smbsl_slave_flt_i (.i_ref_clk(clk),
      .i_reset(rst), .link(smbsl_link_if_2), .i_tx_data(txd), .o_rx_data(), .o_rx_valid(),
      .o_rx_first(), .o_tx_taken(), .o_start(sstart2), .o_stop(), .o_timeout(sto2),
      .o_ready());
   smbsl_link_asserts #(.OWN_ADDR(DEFAULT_ADDR)) smbsl_link_asserts_i (.i_ref_clk(clk),
      .i_reset(rst), .s_sda_oe(smbsl_link_if_i.s_sda_oe),
      .serial_clock_pin(smbsl_link_if_i.serial_clock_pin),
      .serial_data_pin(smbsl_link_if_i.serial_data_pin));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (srv === 1'b1)
      begin
         nrx++;
         lastrx    = srx;
         lastfirst = sfirst;
      end
      nstart  += (sstart === 1'b1);
      nstop   += (sstop === 1'b1);
      ntaken  += (staken === 1'b1);
      nstart2 += (sstart2 === 1'b1);
   end

   always @(posedge smbsl_link_if_i.serial_clock_pin)
      wire_sr = {wire_sr[7:0], smbsl_link_if_i.serial_data_pin};

   ////////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic s, input logic p, input logic r, input logic l,
                       input logic [7:0] b);
      repeat (100) if (busy === 1'b1) @(negedge clk);
      {req, st, sp, rd, last, byt} = {1'b1, s, p, r, l, b};
      repeat (100) if (busy !== 1'b1) @(negedge clk);
      req = 1'b0;
      repeat (3000) if (done !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask

   // one quarter of a 64 ns bit on the second link; open drain, so high means released
   task automatic bb(input logic c, input logic d);
      @(negedge clk);
      smbsl_link_if_2.m_scl_oe = !c;
      smbsl_link_if_2.m_sda_oe = !d;
      repeat (3) @(negedge clk);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {req, st, sp, rd, last, byt, txd, rst} = {5'h00, 8'h00, 8'hC3, 1'b1};
      {smbsl_link_if_2.m_scl_o, smbsl_link_if_2.m_sda_o} = 2'h0;
      {smbsl_link_if_2.m_scl_oe, smbsl_link_if_2.m_sda_oe} = 2'h0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      `CHK("ready at release", 1'b0, srdy)
      `CHK("idle clock", 1'b1, smbsl_link_if_i.serial_clock_pin)
      `CHK("idle data", 1'b1, smbsl_link_if_i.serial_data_pin)
      repeat (RDY_CYC + 4) @(negedge clk);
      `CHK("ready", 1'b1, srdy)
      // write two bytes
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEFAULT_ADDR, 1'b0});
      `CHK("address ack", 1'b1, acked)
      // last nine clocks: address, write bit, then the slave's low ack
      `CHK("address on wire", {DEFAULT_ADDR, 2'h0}, wire_sr)
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'hA5);
      `CHK("byte ack", 1'b1, acked)
      `CHK("rx byte", 8'hA5, lastrx)
      `CHK("rx first", 1'b1, lastfirst)
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h3C);
      `CHK("last ack", 1'b1, acked)
      `CHK("rx byte", 8'h3C, lastrx)
      `CHK("rx not first", 1'b0, lastfirst)
      `CHK("starts", 1, nstart)
      `CHK("stops", 1, nstop)
      // foreign address is neither acked nor received
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {7'h2D, 1'b0});
      `CHK("foreign ack", 1'b0, acked)
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h77);
      `CHK("foreign byte", 1'b0, acked)
      `CHK("rx count", 2, nrx)
      // pointer write, repeated start, two reads with fresh results
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEFAULT_ADDR, 1'b0});
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h10);
      // the address byte is always sent by the master, read bit or not
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEFAULT_ADDR, 1'b1});
      `CHK("read address ack", 1'b1, acked)
      `CHK("repeated start", 4, nstart)
      xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
      `CHK("read byte", 8'hC3, rxb)
      txd = 8'h5A;
      xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
      `CHK("read last", 8'h5A, rxb)
      `CHK("loads", 2, ntaken)
      `CHK("stops after read", 3, nstop)
      // clock held low in the ninth clock on the second link
      a = {DEFAULT_ADDR, 1'b0};
      bb(1'b1, 1'b1);
      bb(1'b1, 1'b0);
      bb(1'b0, 1'b0);
      for (i = 7; i >= 0; i--)
      begin
         bb(1'b0, a[i]);
         bb(1'b1, a[i]);
         bb(1'b1, a[i]);
         bb(1'b0, a[i]);
      end
      bb(1'b0, 1'b1);
      `CHK("fault start", 1, nstart2)
      `CHK("fault ack", 1'b1, smbsl_link_if_2.s_sda_oe)
      repeat (TO_CYC - 100) @(negedge clk);
      `CHK("early timeout", 1'b0, sto2)
      repeat (200) @(negedge clk);
      `CHK("timeout", 1'b1, sto2)
      `CHK("data released", 1'b0, smbsl_link_if_2.s_sda_oe)
      // one-cycle dip with clock high is too short to be a start
      bb(1'b1, 1'b1);
      smbsl_link_if_2.m_sda_oe = 1'b1;
      @(negedge clk);
      smbsl_link_if_2.m_sda_oe = 1'b0;
      repeat (20) @(negedge clk);
      `CHK("glitch ignored", 1, nstart2)
      test_done();
   end
endmodule
`default_nettype wire
